/* File: testbench/bil_flash_model.sv */
// Flash partner: answers header and image requests with word streams
`timescale 1ns/1ps
module bil_flash_model (
    // Clock
    input wire logic clk_sys_i,
    // Image setup from the bench
    input wire logic [2:0] present_i,
    input wire logic [2:0][6:0][31:0] img_i,
    // Request and stream
    input wire bil_pkg::bil_req_t req_i,
    output logic ack_o,
    output logic fail_o,
    output logic valid_o,
    input wire logic ready_i,
    output logic [31:0] data_o
);
    import bil_pkg::*;
    int seed = 31376;
    logic busy = 1'h0;
    logic vld = 1'h0;
    logic [1:0] s;
    logic [31:0] k, n, base, dat;
    assign valid_o = vld;
    // Idle line shows inverse of last word
    assign data_o = vld ? dat : ~dat;
    initial begin
        ack_o = 1'h0;
        fail_o = 1'h0;
        dat = 32'h0;
    end
    always @(posedge clk_sys_i) begin
        ack_o <= 1'h0;
        fail_o <= 1'h0;
        if (vld && ready_i) begin
            vld <= 1'h0;
            k <= k + 1;
            busy <= (k + 1 < n);
        end else if (busy && !vld && ($random(seed) & 3) != 0) begin
            vld <= 1'h1;
            dat <= (base + k < 7) ? img_i[s][base + k] : 32'hC0DE_0000 | (base + k);
        end
        if (req_i.valid && !busy && !ack_o && !fail_o) begin
            s <= req_i.src[0] ? 2'h0 : req_i.src[1] ? 2'h1 : 2'h2;
            if (present_i & req_i.src) begin
                ack_o <= 1'h1;
                busy <= 1'h1;
                k <= 32'h0;
                n <= req_i.len >> 2;
                base <= req_i.addr >> 2;
            end else begin
                fail_o <= 1'h1;
            end
        end
    end
endmodule

/* File: testbench/test_boot_image_loader_sequencer.sv */
// Bench: boots from first chip select and from NAND, then the monitor fallback
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
    $display("ERROR %0t: got %h expected %h", $time, (g), (e)); end end
module test_boot_image_loader_sequencer;
    import bil_pkg::*;
    logic clk_sys_i, rst_n_i, ce_i, slow_osc_source_select_i, osc_bypass_i, ext_clk_present_i;
    logic [15:0] power_manager_osc_khz_i;
    bil_step_t step_o;
    bil_req_t rd_req_o;
    logic [16:0] debug_serial_port_baud_o;
    logic [31:0] jump_addr_o, rd_data_i, sram_addr_o, sram_data_o;
    logic [2:0] cur_src_o, present;
    logic [7:0] usb_pll_mul_o;
    logic usb_boot_ok_o, boot_done_o, in_monitor_o, rd_ack_i, rd_fail_i, rd_valid_i, rd_ready_o;
    logic sram_we_o, sram_ready_i, usb_rx_i, debug_serial_port_rx_i, mon_link_o;
    logic [2:0][6:0][31:0] img;
    logic [63:0] q[$];
    int seed = 31376;
    int n_fail = 0;
    int check_count = 0;

    bil_top dut_u (.clk_sys_i, .rst_n_i, .ce_i, .slow_osc_source_select_i, .osc_bypass_i,
        .ext_clk_present_i, .power_manager_osc_khz_i, .step_o, .usb_pll_mul_o,
        .usb_boot_ok_o, .debug_serial_port_baud_o, .jump_addr_o, .boot_done_o, .in_monitor_o,
        .cur_src_o, .rd_req_o, .rd_ack_i, .rd_fail_i, .rd_valid_i, .rd_ready_o, .rd_data_i,
        .sram_we_o, .sram_addr_o, .sram_data_o, .sram_ready_i, .usb_rx_i,
        .debug_serial_port_rx_i, .mon_link_o);
    bil_flash_model flash_u (.clk_sys_i, .present_i(present), .img_i(img), .req_i(rd_req_o),
        .ack_o(rd_ack_i), .fail_o(rd_fail_i), .valid_o(rd_valid_i), .ready_i(rd_ready_o),
        .data_o(rd_data_i));

    initial begin
        clk_sys_i = 1'h0;
        forever #2.5 clk_sys_i = ~clk_sys_i;
    end
    // SRAM stalls at random
    always @(posedge clk_sys_i) #1 sram_ready_i <= ($random(seed) & 3) != 0;

    // ------------------------------------------------------------------
    // Monitor: each step pulse or SRAM write takes the oldest note
    // ------------------------------------------------------------------
    always @(posedge clk_sys_i) begin
        logic [63:0] e;
        if (rst_n_i) begin
            if (step_o !== '0) begin
                e = q.size() ? q.pop_front() : '1;
                `CHK({32'hFFFF_FFFF, 19'h0, step_o}, e)
            end
            if (sram_we_o && sram_ready_i) begin
                e = q.size() ? q.pop_front() : '1;
                `CHK({sram_addr_o, sram_data_o}, e)
            end
        end
    end

    function automatic logic [63:0] st(int b);
        return {32'hFFFF_FFFF, 32'h1 << b};
    endfunction
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic prep(input logic s, b, x, input logic [15:0] f, input logic [2:0] p);
        rst_n_i = 1'h0;
        slow_osc_source_select_i = s;
        osc_bypass_i = b;
        ext_clk_present_i = x;
        power_manager_osc_khz_i = f;
        present = p;
        for (int i = 12; i >= 6; i--) begin
            if (!(i == 7 && x)) q.push_back(st(i));
        end
        if (s) q.push_back(st(5));
    endtask
    task automatic go();
        int i = 0;
        repeat (4) @(posedge clk_sys_i);
        #1 rst_n_i = 1'h1;
        while ((boot_done_o | in_monitor_o) !== 1'h1) begin
            @(posedge clk_sys_i);
            if (++i > 20000) begin
                n_fail++;
                report_and_stop();
            end
        end
        repeat (3) @(posedge clk_sys_i);
        #1 `CHK(q.size(), 0)
    endtask

    initial begin
        {ce_i, usb_rx_i, debug_serial_port_rx_i, sram_ready_i} = 4'h8;
        prep(1'h0, 1'h0, 1'h0, F_6M, 3'h1);
        for (int i = 0; i < 7; i++) img[0][i] = 32'hEA00_0000 | i;
        img[0][5] = 32'h0000_0010;
        for (int i = 0; i < 4; i++) q.push_back({32'(i * 4), img[0][i]});
        q.push_back(st(4));
        go();
        `CHK(usb_boot_ok_o, 1'h1)
        `CHK(usb_pll_mul_o, 8'(USB_CLK_MHZ / 6))
        `CHK({debug_serial_port_baud_o, jump_addr_o, cur_src_o}, {17'h0, 32'h0, 3'h1})
        prep(1'h1, 1'h1, 1'h1, F_50M, 3'h6);
        for (int i = 0; i < 7; i++) begin
            img[1][i] = 32'hEA00_0000 | i;
            img[2][i] = i[0] ? 32'hE53F_F000 : 32'hE5BF_F000;
        end
        img[1][3] = 32'hE59F_F000;
        img[2][5] = 32'h0000_0010;
        for (int i = 0; i < 1024; i++) begin
            q.push_back({32'(i * 4), i < 7 ? img[2][i] : 32'hC0DE_0000 | i});
        end
        q.push_back(st(4));
        go();
        `CHK(usb_boot_ok_o, 1'h1)
        `CHK({debug_serial_port_baud_o, cur_src_o}, {17'h1C200, 3'h4})
        prep(1'h0, 1'h1, 1'h0, F_20M, 3'h5);
        img[0][2] = 32'hDA00_0000;
        img[2] = img[1];
        img[2][3] = 32'hEA00_0003;
        img[2][6] = 32'hEB00_0006;
        for (int i = 3; i >= 0; i--) q.push_back(st(i));
        go();
        `CHK({usb_boot_ok_o, in_monitor_o, mon_link_o}, 3'h2)
        debug_serial_port_rx_i = 1'h1;
        @(posedge clk_sys_i);
        #1 debug_serial_port_rx_i = 1'h0;
        repeat (2) @(posedge clk_sys_i);
        #1 `CHK(mon_link_o, 1'h0)
        usb_rx_i = 1'h1;
        @(posedge clk_sys_i);
        #1 usb_rx_i = 1'h0;
        repeat (2) @(posedge clk_sys_i);
        #1 `CHK(mon_link_o, 1'h1)
        report_and_stop();
    end
endmodule

/* File: verilog/bil_fifo.sv */
// Small word FIFO between flash reader and SRAM writer
`timescale 1ns/1ps
module bil_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 4
) (
    // Clock and reset
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    input wire logic flush_i,
    // Write side
    input wire logic in_valid_i,
    output logic in_ready_o,
    input wire logic [WIDTH-1:0] in_data_i,
    // Read side
    output logic out_valid_o,
    input wire logic out_ready_i,
    output logic [WIDTH-1:0] out_data_o
);
    localparam int unsigned AW = $clog2(DEPTH);
    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0] cnt;
    } bil_fifo_st_t;
    bil_fifo_st_t s_r, s_nxt;
    logic push, pop;

    assign in_ready_o = (s_r.cnt != (AW+1)'(DEPTH));
    assign out_valid_o = (s_r.cnt != '0);
    assign out_data_o = s_r.mem[s_r.rp];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always_comb begin
        s_nxt = s_r;
        if (flush_i) begin
            s_nxt.wp = '0;
            s_nxt.rp = '0;
            s_nxt.cnt = '0;
        end else begin
            if (push) begin
                s_nxt.mem[s_r.wp] = in_data_i;
                s_nxt.wp = (s_r.wp == AW'(DEPTH - 1)) ? '0 : s_r.wp + 1'b1;
            end
            if (pop) begin
                s_nxt.rp = (s_r.rp == AW'(DEPTH - 1)) ? '0 : s_r.rp + 1'b1;
            end
            s_nxt.cnt = s_r.cnt + (AW+1)'(push) - (AW+1)'(pop);
        end
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else if (ce_i) begin
            s_r <= s_nxt;
        end
    end

    property p_no_overflow;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        s_r.cnt <= (AW+1)'(DEPTH);
    endproperty
    a_no_overflow: assert property (p_no_overflow) else $error("fifo count over depth");
endmodule

/* File: verilog/bil_pkg.sv */
// Package: constants, types and states of the boot image loader sequencer
// ----------------------------------------------------------------------------
// Function
// - Init steps run in order: fast irq, stack, ext clock, mck switch, vars, pll
// - Main oscillator measured only when no external clock was detected
// - USB PLL factor toward 48 MHz chosen from oscillator value; nonzero only for 1, 2, 3, 6, 12 MHz
// - RC source, crystal: USB boot only for 3.0, 6.0, 18.432 MHz
// - RC source, bypass: USB boot only for 1, 2, 6, 12, 25, 50 MHz
// - 32 kHz source, crystal: both boots for listed crystals 3.0 to 20.0 MHz
// - 32 kHz source, bypass: both boots for listed inputs up to 50.0 MHz
// - Debug serial port set 115200 8N1 only when slow source select is 1
// - First try serial flash on first chip select; success remaps, jumps zero
// - On failure retry serial flash on second chip select
// - Both serial attempts failing, try NAND; success remaps, jumps zero
// - All fail: icache on, monitor, watchdog off, USB port init, in order
// - Valid image copied to SRAM, then remap, then branch to zero
// - Image valid if seven leading vectors are branch or PC-relative loads
// - Word at 0x14 not checked; its byte count is the length for serial flash, NAND copies a fixed 0x1000
// - Each checked vector needs condition code 0xE in bits 31..28
// - Load vector: base and dest fields 0xF, load, pre-index, writeback set
// - Monitor waits for traffic on USB port, or on debug serial port when slow source select is 1
// ----------------------------------------------------------------------------
package bil_pkg;
    localparam int unsigned VEC_COUNT = 7;
    localparam logic [2:0] SIZE_VEC_IDX = 3'h5;
    localparam logic [31:0] SIZE_VEC_OFS = 32'h0000_0014;
    localparam logic [3:0] COND_ALWAYS = 4'hE;
    localparam logic [3:0] BRANCH_OPC = 4'hA;
    localparam logic [3:0] PC_REG = 4'hF;
    localparam logic [31:0] JUMP_ADDR = 32'h0000_0000;
    localparam logic [31:0] SRAM_LIMIT = 32'h0000_1000;
    localparam logic [31:0] NAND_FIXED_SIZE = 32'h0000_1000;
    localparam int unsigned FIFO_DEPTH = 4;
    localparam int unsigned FIFO_WIDTH = 32;
    localparam int unsigned USB_CLK_MHZ = 48;
    localparam logic [16:0] DBG_BAUD = 17'h1C200;
    // Oscillator codes (kHz) of the measured main clock
    localparam logic [15:0] F_1M = 16'h03E8;
    localparam logic [15:0] F_2M = 16'h07D0;
    localparam logic [15:0] F_3M = 16'h0BB8;
    localparam logic [15:0] F_6M = 16'h1770;
    localparam logic [15:0] F_12M = 16'h2EE0;
    localparam logic [15:0] F_18M = 16'h4800;
    localparam logic [15:0] F_20M = 16'h4E20;
    localparam logic [15:0] F_25M = 16'h61A8;
    localparam logic [15:0] F_50M = 16'hC350;

    typedef enum logic [2:0] {
        BIL_SRC_SPI0 = 3'h1,
        BIL_SRC_SPI1 = 3'h2,
        BIL_SRC_NAND = 3'h4
    } bil_src_t;

    typedef enum logic [19:0] {
        ST_FIQ = 20'h00001,
        ST_STACK = 20'h00002,
        ST_EXTCLK = 20'h00004,
        ST_MCK = 20'h00008,
        ST_VARS = 20'h00010,
        ST_MEAS = 20'h00020,
        ST_PLL = 20'h00040,
        ST_DBG = 20'h00080,
        ST_REQHDR = 20'h00100,
        ST_HDR = 20'h00200,
        ST_CHECK = 20'h00400,
        ST_REQIMG = 20'h00800,
        ST_COPY = 20'h01000,
        ST_REMAP = 20'h02000,
        ST_JUMP = 20'h04000,
        ST_ICACHE = 20'h08000,
        ST_MON = 20'h10000,
        ST_WDOG = 20'h20000,
        ST_USB = 20'h40000,
        ST_WAIT = 20'h80000
    } bil_state_t;

    // Word request toward the flash reader
    typedef struct packed {
        logic valid;
        bil_src_t src;
        logic [31:0] addr;
        logic [31:0] len;
    } bil_req_t;

    // Clock plan result
    typedef struct packed {
        logic usb_ok;
        logic dbg_ok;
        logic [7:0] pll_mul;
    } bil_clk_t;

    // One action strobe per init/fallback step
    typedef struct packed {
        logic fiq_init;
        logic stack_init;
        logic extclk_detect;
        logic mck_switch;
        logic var_init;
        logic osc_measure;
        logic pll_setup;
        logic dbg_init;
        logic remap;
        logic icache_on;
        logic monitor_enter;
        logic wdog_off;
        logic usb_init;
    } bil_step_t;
endpackage

/* File: verilog/bil_top.sv */
// Boot image loader sequencer: init, image search, copy, remap, fallback
`timescale 1ns/1ps
module bil_top
    import bil_pkg::*;
(
    // Clock, reset, enable
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire logic ce_i,
    // Clock environment
    input wire logic slow_osc_source_select_i,
    input wire logic osc_bypass_i,
    input wire logic ext_clk_present_i,
    input wire logic [15:0] power_manager_osc_khz_i,
    // Step strobes and status
    output bil_pkg::bil_step_t step_o,
    output logic [7:0] usb_pll_mul_o,
    output logic usb_boot_ok_o,
    output logic [16:0] debug_serial_port_baud_o,
    output logic [31:0] jump_addr_o,
    output logic boot_done_o,
    output logic in_monitor_o,
    output logic [2:0] cur_src_o,
    // Flash reader request
    output bil_pkg::bil_req_t rd_req_o,
    input wire logic rd_ack_i,
    input wire logic rd_fail_i,
    // Flash word stream
    input wire logic rd_valid_i,
    output logic rd_ready_o,
    input wire logic [31:0] rd_data_i,
    // SRAM write port
    output logic sram_we_o,
    output logic [31:0] sram_addr_o,
    output logic [31:0] sram_data_o,
    input wire logic sram_ready_i,
    // Monitor traffic
    input wire logic usb_rx_i,
    input wire logic debug_serial_port_rx_i,
    output logic mon_link_o
);
    typedef struct packed {
        bil_state_t st;
        bil_src_t src;
        bil_step_t step;
        logic [2:0] vidx;
        logic [31:0] len;
        logic [31:0] cnt;
        logic ok;
        logic ext_clk;
        bil_clk_t clk;
        logic [16:0] baud;
        bil_req_t req;
        logic we;
        logic [31:0] waddr;
        logic [31:0] wdata;
        logic done;
        logic link;
    } bil_st_t;

    bil_st_t s_r, s_nxt;
    bil_clk_t clk_plan;
    logic vec_ok, f_valid, f_ready, w_acc;
    logic [31:0] f_data;

    // ------------------------------------------------------------------------
    // Vector checker and FIFO
    // ------------------------------------------------------------------------
    bil_vec_check u_chk (
        .vec_i(f_data),
        .idx_i(s_r.vidx),
        .vec_ok_o(vec_ok),
        .slow_osc_source_select_i(slow_osc_source_select_i),
        .osc_bypass_i(osc_bypass_i),
        .osc_khz_i(power_manager_osc_khz_i),
        .clk_o(clk_plan)
    );

    bil_fifo #(.WIDTH(FIFO_WIDTH), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk_sys_i(clk_sys_i),
        .rst_n_i(rst_n_i),
        .ce_i(ce_i),
        .flush_i(s_r.st == ST_CHECK),
        .in_valid_i(rd_valid_i),
        .in_ready_o(rd_ready_o),
        .in_data_i(rd_data_i),
        .out_valid_o(f_valid),
        .out_ready_i(f_ready),
        .out_data_o(f_data)
    );

    // Header words pop freely; image words pop when SRAM write slot free
    assign w_acc = !s_r.we || sram_ready_i;
    assign f_ready = (s_r.st == ST_HDR) || ((s_r.st == ST_COPY) && w_acc);

    // ------------------------------------------------------------------------
    // Sequencer
    // ------------------------------------------------------------------------
    always_comb begin
        s_nxt = s_r;
        s_nxt.step = '0;
        if (s_r.we && sram_ready_i) begin
            s_nxt.we = 1'b0;
        end
        if (s_r.req.valid && (rd_ack_i || rd_fail_i)) begin
            s_nxt.req.valid = 1'b0;
        end
        case (s_r.st)
            ST_FIQ: begin
                s_nxt.step.fiq_init = 1'b1;
                s_nxt.st = ST_STACK;
            end
            ST_STACK: begin
                s_nxt.step.stack_init = 1'b1;
                s_nxt.st = ST_EXTCLK;
            end
            ST_EXTCLK: begin
                s_nxt.step.extclk_detect = 1'b1;
                s_nxt.ext_clk = ext_clk_present_i;
                s_nxt.st = ST_MCK;
            end
            ST_MCK: begin
                s_nxt.step.mck_switch = 1'b1;
                s_nxt.st = ST_VARS;
            end
            ST_VARS: begin
                s_nxt.step.var_init = 1'b1;
                s_nxt.st = s_r.ext_clk ? ST_PLL : ST_MEAS;
            end
            ST_MEAS: begin
                s_nxt.step.osc_measure = 1'b1;
                s_nxt.st = ST_PLL;
            end
            ST_PLL: begin
                s_nxt.step.pll_setup = 1'b1;
                s_nxt.clk = clk_plan;
                s_nxt.st = ST_DBG;
            end
            ST_DBG: begin
                if (slow_osc_source_select_i) begin
                    s_nxt.step.dbg_init = 1'b1;
                    s_nxt.baud = DBG_BAUD;
                end
                s_nxt.src = BIL_SRC_SPI0;
                s_nxt.st = ST_REQHDR;
            end
            ST_REQHDR: begin
                s_nxt.req.valid = 1'b1;
                s_nxt.req.src = s_r.src;
                s_nxt.req.addr = JUMP_ADDR;
                s_nxt.req.len = 32'(VEC_COUNT * 4);
                s_nxt.vidx = '0;
                s_nxt.ok = 1'b1;
                s_nxt.st = ST_HDR;
            end
            ST_HDR: begin
                if (s_r.req.valid && rd_fail_i) begin
                    s_nxt.ok = 1'b0;
                    s_nxt.st = ST_CHECK;
                end else if (f_valid) begin
                    s_nxt.ok = s_r.ok && vec_ok;
                    if (s_r.vidx == SIZE_VEC_IDX) begin
                        s_nxt.len = f_data;
                    end
                    s_nxt.vidx = s_r.vidx + 3'h1;
                    if (s_r.vidx == 3'(VEC_COUNT - 1)) begin
                        s_nxt.st = ST_CHECK;
                    end
                end
            end
            ST_CHECK: begin
                if (s_r.ok) begin
                    if (s_r.src == BIL_SRC_NAND) begin
                        s_nxt.len = NAND_FIXED_SIZE;
                    end
                    s_nxt.st = ST_REQIMG;
                end else begin
                    case (s_r.src)
                        BIL_SRC_SPI0: begin
                            s_nxt.src = BIL_SRC_SPI1;
                            s_nxt.st = ST_REQHDR;
                        end
                        BIL_SRC_SPI1: begin
                            s_nxt.src = BIL_SRC_NAND;
                            s_nxt.st = ST_REQHDR;
                        end
                        default: s_nxt.st = ST_ICACHE;
                    endcase
                end
            end
            ST_REQIMG: begin
                s_nxt.req.valid = 1'b1;
                s_nxt.req.src = s_r.src;
                s_nxt.req.addr = JUMP_ADDR;
                s_nxt.req.len = s_r.len;
                s_nxt.cnt = '0;
                s_nxt.st = ST_COPY;
            end
            ST_COPY: begin
                if (s_r.cnt >= s_r.len) begin
                    s_nxt.st = ST_REMAP;
                end else if (f_valid && w_acc) begin
                    s_nxt.we = 1'b1;
                    s_nxt.waddr = s_r.cnt;
                    s_nxt.wdata = f_data;
                    s_nxt.cnt = s_r.cnt + 32'h0000_0004;
                end
            end
            ST_REMAP: begin
                if (!s_r.we) begin
                    s_nxt.step.remap = 1'b1;
                    s_nxt.st = ST_JUMP;
                end
            end
            ST_JUMP: begin
                s_nxt.done = 1'b1;
            end
            ST_ICACHE: begin
                s_nxt.step.icache_on = 1'b1;
                s_nxt.st = ST_MON;
            end
            ST_MON: begin
                s_nxt.step.monitor_enter = 1'b1;
                s_nxt.st = ST_WDOG;
            end
            ST_WDOG: begin
                s_nxt.step.wdog_off = 1'b1;
                s_nxt.st = ST_USB;
            end
            ST_USB: begin
                s_nxt.step.usb_init = 1'b1;
                s_nxt.st = ST_WAIT;
            end
            ST_WAIT: begin
                if (usb_rx_i || (debug_serial_port_rx_i && slow_osc_source_select_i)) begin
                    s_nxt.link = 1'b1;
                end
            end
            default: s_nxt.st = ST_FIQ;
        endcase
    end

    always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '{st: ST_FIQ, src: BIL_SRC_SPI0, default: '0};
        end else if (ce_i) begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign step_o = s_r.step;
    assign usb_pll_mul_o = s_r.clk.pll_mul;
    assign usb_boot_ok_o = s_r.clk.usb_ok;
    assign debug_serial_port_baud_o = s_r.baud;
    assign jump_addr_o = JUMP_ADDR;
    assign boot_done_o = s_r.done;
    assign in_monitor_o = (s_r.st == ST_WAIT);
    assign cur_src_o = s_r.src;
    assign rd_req_o = s_r.req;
    assign sram_we_o = s_r.we;
    assign sram_addr_o = s_r.waddr;
    assign sram_data_o = s_r.wdata;
    assign mon_link_o = s_r.link;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    property p_init_order;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && step_o.fiq_init ##1 ce_i |-> step_o.stack_init;
    endproperty
    a_init_order: assert property (p_init_order) else $error("stack after fiq");

    property p_meas_skip;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        step_o.osc_measure |-> !s_r.ext_clk;
    endproperty
    a_meas_skip: assert property (p_meas_skip) else $error("measured with ext clock");

    property p_dbg_sel;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        step_o.dbg_init |-> $past(slow_osc_source_select_i) && (s_r.baud == DBG_BAUD);
    endproperty
    a_dbg_sel: assert property (p_dbg_sel) else $error("debug port init wrong");

    property p_retry;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && s_r.st == ST_CHECK && !s_r.ok && s_r.src == BIL_SRC_SPI0
        |=> s_r.src == BIL_SRC_SPI1;
    endproperty
    a_retry: assert property (p_retry) else $error("no retry on second select");

    property p_nand;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && s_r.st == ST_CHECK && !s_r.ok && s_r.src == BIL_SRC_SPI1
        |=> s_r.src == BIL_SRC_NAND;
    endproperty
    a_nand: assert property (p_nand) else $error("no NAND attempt");

    property p_fallback;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && step_o.icache_on ##1 ce_i ##1 ce_i
        |-> $past(step_o.monitor_enter) && step_o.wdog_off ##1 step_o.usb_init;
    endproperty
    a_fallback: assert property (p_fallback) else $error("fallback order broken");

    property p_remap_first;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        $rose(boot_done_o) |-> $past(s_r.st) == ST_JUMP && $past(step_o.remap) && !sram_we_o;
    endproperty
    a_remap_first: assert property (p_remap_first) else $error("jump before remap");

    property p_cond;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && s_r.st == ST_HDR && f_valid && s_r.vidx != SIZE_VEC_IDX
        && f_data[31:28] != COND_ALWAYS |=> !s_r.ok;
    endproperty
    a_cond: assert property (p_cond) else $error("bad condition accepted");

    property p_len;
        @(posedge clk_sys_i) disable iff (!rst_n_i)
        ce_i && s_r.st == ST_HDR && f_valid && s_r.vidx == SIZE_VEC_IDX
        |=> s_r.len == $past(f_data);
    endproperty
    a_len: assert property (p_len) else $error("size word not taken");

    c_boot: cover property (@(posedge clk_sys_i) $rose(boot_done_o));
    c_spi1: cover property (@(posedge clk_sys_i) s_r.src == BIL_SRC_SPI1 && s_r.st == ST_COPY);
    c_mon: cover property (@(posedge clk_sys_i) $rose(mon_link_o));
endmodule

/* File: verilog/bil_vec_check.sv */
// Exception vector checker and clock plan lookup
`timescale 1ns/1ps
module bil_vec_check
    import bil_pkg::*;
(
    // Vector check
    input wire logic [31:0] vec_i,
    input wire logic [2:0] idx_i,
    output logic vec_ok_o,
    // Clock plan
    input wire logic slow_osc_source_select_i,
    input wire logic osc_bypass_i,
    input wire logic [15:0] osc_khz_i,
    output bil_pkg::bil_clk_t clk_o
);
    logic is_branch, is_load;

    always_comb begin
        is_branch = (vec_i[27:24] == BRANCH_OPC);
        is_load = (vec_i[27:25] == 3'h2) && vec_i[24] && vec_i[21] && vec_i[20]
            && !vec_i[22] && (vec_i[19:16] == PC_REG) && (vec_i[15:12] == PC_REG);
        if (idx_i == SIZE_VEC_IDX) begin
            vec_ok_o = 1'b1;
        end else begin
            vec_ok_o = (vec_i[31:28] == COND_ALWAYS) && (is_branch || is_load);
        end
    end

    always_comb begin
        clk_o.dbg_ok = 1'b1;
        clk_o.usb_ok = 1'b0;
        if (slow_osc_source_select_i) begin
            // Crystal path supports inputs 3 to 20 MHz; bypass path supports inputs up to 50 MHz
            clk_o.usb_ok = osc_bypass_i ? (osc_khz_i <= F_50M) : (osc_khz_i >= F_3M)
                && (osc_khz_i <= F_20M);
        end else if (osc_bypass_i) begin
            case (osc_khz_i)
                F_1M, F_2M, F_6M, F_12M, F_25M, F_50M: clk_o.usb_ok = 1'b1;
                default: clk_o.usb_ok = 1'b0;
            endcase
        end else begin
            case (osc_khz_i)
                F_3M, F_6M, F_18M: clk_o.usb_ok = 1'b1;
                default: clk_o.usb_ok = 1'b0;
            endcase
        end
        // Multiplier toward 48 MHz for exact 1, 2, 3, 6, 12 MHz codes; other values give zero
        clk_o.pll_mul = 8'h00;
        case (osc_khz_i)
            F_1M: clk_o.pll_mul = 8'h30;
            F_2M: clk_o.pll_mul = 8'h18;
            F_3M: clk_o.pll_mul = 8'h10;
            F_6M: clk_o.pll_mul = 8'h08;
            F_12M: clk_o.pll_mul = 8'h04;
            default: clk_o.pll_mul = 8'h00;
        endcase
    end
endmodule
